// *** core/ocr_pkg.sv ***
package ocr_pkg;
  // bus geometry
  localparam int AXI_AW = 16;
  localparam int AXI_DW = 32;
  // printed offsets are not byte addresses (0x000C is a multiple of four, 0x1EFE is not)
  // so each offset is an index and the byte address is four times it
  localparam logic [15:0] IDX_MISC = 16'h000C;
  localparam logic [15:0] IDX_OPTS = 16'h1EFE;
  localparam logic [15:0] IDX_CTRL = 16'h0100;  // bootloader mode control: bit 0 reads boot mode, writing it zero leaves boot mode
  localparam logic [17:0] ADDR_MISC = {IDX_MISC, 2'b00};
  localparam logic [17:0] ADDR_OPTS = {IDX_OPTS, 2'b00};
  localparam logic [17:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  // options register fields
  localparam int OPT_FACTORY = 7;
  localparam int OPT_PROTECT = 6;
  localparam int OPT_HOLDSEL = 4;
  localparam int OPT_WDRST = 3;
  localparam int OPT_WDWAIT = 2;
  localparam logic [7:0] OPT_WMASK = 8'h7F;
  localparam logic [7:0] OPT_ERASED = 8'h00;
  // misc register fields
  localparam int MISC_POR = 7;
  localparam int MISC_WATCHDOG_ACTIVE_BIT = 0;
  // reset hold counts
  localparam int HOLD_SHORT_CYC = 16;
  localparam int HOLD_LONG_CYC = 4064;
  // response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic protect;
    logic hold_short;
    logic wd_after_reset;
    logic wd_in_wait;
  } ocr_opts_t;
endpackage : ocr_pkg

// *** core/ocr_nv_cell.sv ***
`timescale 1ns/10ps
// nonvolatile byte model: no reset input at all, so no reset can alter it
module ocr_nv_cell (
  input wire logic i_clk_sys,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  import ocr_pkg::*;
  logic [7:0] cell_r = OPT_ERASED;  // power-up content of an erased cell

  // no reset branch on purpose
  always_ff @(posedge i_clk_sys) begin
    if (i_wr) begin
      cell_r <= i_wdata & OPT_WMASK;
    end
  end
  assign o_rdata = cell_r & OPT_WMASK;  // factory bit always reads zero
endmodule : ocr_nv_cell

// *** core/ocr_hold_timer.sv ***
`timescale 1ns/10ps
// holds the reset pin low after power-on for 16 or 4064 cycles
module ocr_hold_timer #(
  parameter int HOLD_LONG = ocr_pkg::HOLD_LONG_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_por,
  input wire logic i_short,
  output logic o_hold
);
  import ocr_pkg::*;
  // refuse lengths the 16-bit counter cannot hold, checked at elaboration
  if (HOLD_LONG < HOLD_SHORT_CYC || HOLD_LONG > 65535) begin : g_bad_hold
    $error("hold length out of range");
  end
  logic [15:0] cnt_r;
  logic armed_r;
  logic [15:0] len_w;
  assign len_w = i_short ? 16'(HOLD_SHORT_CYC) : 16'(HOLD_LONG);

  // counter loads on the first clock after power-on release
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 16'h0000;
      armed_r <= 1'b0;
    end else if (i_por && !armed_r) begin
      cnt_r <= len_w - 16'h0001;
      armed_r <= 1'b1;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
  assign o_hold = (i_por && !armed_r) || (cnt_r != 16'h0000);
endmodule : ocr_hold_timer

// *** core/ocr_top.sv ***
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module ocr_top #(
  parameter int HOLD_LONG = ocr_pkg::HOLD_LONG_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_por,                // power-on reset flavour of this reset
  input wire logic i_boot_mode,          // bootloader / bootstrap mode strap
  input wire logic i_wait_mode,          // core is in WAIT
  input wire logic i_eprom_wr_req,       // core wants to program main EPROM
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic o_reset_pin_low,          // reset pin driven low
  output logic o_eprom_wr_ok,            // EPROM write allowed this cycle
  output logic o_wd_run,                 // watchdog counter runs
  output logic [7:0] o_opts              // live options byte
);
  import ocr_pkg::*;

  // write channel capture
  logic aw_have_r, w_have_r;
  logic [17:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [7:0] nv_q;
  logic por_flag_r, watchdog_active_bit_r, boot_r, started_r, hold_q;
  ocr_opts_t opt_w;

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  wire wr_opts = wr_go && aw_addr_r == ADDR_OPTS;
  wire wr_misc = wr_go && aw_addr_r == ADDR_MISC;
  wire wr_ctrl = wr_go && aw_addr_r == ADDR_CTRL;
  wire wr_known = wr_opts || wr_misc || wr_ctrl;
  wire opt_allowed = boot_r && w_strb_r[0];
  wire nv_wr = wr_opts && opt_allowed;
  wire [7:0] nv_wdata = {1'b0, w_data_r[6:0]};

  // stored byte is the options register itself
  ocr_nv_cell u_nv (
    .i_clk_sys(i_clk_sys),
    .i_wr(nv_wr),
    .i_wdata(nv_wdata),
    .o_rdata(nv_q)
  );

  assign opt_w.protect = nv_q[OPT_PROTECT];
  assign opt_w.hold_short = nv_q[OPT_HOLDSEL];
  assign opt_w.wd_after_reset = nv_q[OPT_WDRST];
  assign opt_w.wd_in_wait = nv_q[OPT_WDWAIT];

  ocr_hold_timer #(.HOLD_LONG(HOLD_LONG)) u_hold (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_por(i_por),
    .i_short(opt_w.hold_short),
    .o_hold(hold_q)
  );

  // capture address and data in either order
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 18'h00000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_r <= 1'b0;
    end
  end

  // write response: refused options write answers SLVERR
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= !wr_known ? RESP_DECERR :
                     (wr_opts && !opt_allowed) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // boot mode strap caught after reset release, software may leave it
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      started_r <= 1'b0;
      boot_r <= 1'b0;
    end else if (!started_r) begin
      started_r <= 1'b1;
      boot_r <= i_boot_mode;
    end else if (wr_ctrl && w_strb_r[0] && !w_data_r[0]) begin
      boot_r <= 1'b0;  // one-way exit from bootloader mode
    end
  end

  // power-on flag set on por; software clears by writing zero, set wins
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      por_flag_r <= 1'b0;
    end else if (!started_r && i_por) begin
      por_flag_r <= 1'b1;
    end else if (wr_misc && w_strb_r[0] && !w_data_r[MISC_POR]) begin
      por_flag_r <= 1'b0;
    end
  end

  // watchdog enable loads from the option at reset release, not in bootstrap
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      watchdog_active_bit_r <= 1'b0;
    end else if (!started_r) begin
      watchdog_active_bit_r <= opt_w.wd_after_reset && !i_boot_mode;
    end else if (wr_misc && w_strb_r[0] && w_data_r[MISC_WATCHDOG_ACTIVE_BIT]) begin
      watchdog_active_bit_r <= 1'b1;  // software may start it, never stop it
    end
  end

  // read path, one cycle latency
  wire [7:0] misc_q = {por_flag_r, 6'h00, watchdog_active_bit_r};
  wire rd_ok = s_axi_araddr == ADDR_OPTS || s_axi_araddr == ADDR_MISC ||
               s_axi_araddr == ADDR_CTRL;
  wire [7:0] rd_byte = s_axi_araddr == ADDR_OPTS ? nv_q :
                       s_axi_araddr == ADDR_MISC ? misc_q :
                       s_axi_araddr == ADDR_CTRL ? {7'h00, boot_r} : 8'h00;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // registered side outputs
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reset_pin_low <= 1'b1;
      o_eprom_wr_ok <= 1'b0;
      o_wd_run <= 1'b0;
      o_opts <= 8'h00;
    end else begin
      o_reset_pin_low <= hold_q;
      o_eprom_wr_ok <= i_eprom_wr_req && !opt_w.protect;
      o_wd_run <= watchdog_active_bit_r && (!i_wait_mode || opt_w.wd_in_wait);
      o_opts <= nv_q;
    end
  end

  // checks
  property p_protect;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    opt_w.protect |=> !o_eprom_wr_ok;
  endproperty
  protect_blocks_a: assert property (p_protect) else $error("write passed protect");

  no_factory_bit_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    nv_q[OPT_FACTORY] == 1'b0) else $error("bit 7 set");

  boot_only_wr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (wr_opts && !boot_r) |=> $stable(nv_q)) else $error("option written outside boot");

  refused_resp_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (wr_opts && !boot_r) |=> s_axi_bresp == RESP_SLVERR) else $error("bad refusal");

  sequence s_release_por;
    !started_r && i_por;
  endsequence
  por_flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_release_por |=> por_flag_r) else $error("por flag missed");

  watchdog_active_bit_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !started_r |=> watchdog_active_bit_r == (opt_w.wd_after_reset && !boot_r)) else $error("watchdog_active_bit load");

  wait_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_wait_mode && !opt_w.wd_in_wait) |=> !o_wd_run) else $error("wd ran in wait");

  short_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (s_release_por and opt_w.hold_short) |-> ##16 !hold_q) else $error("short hold");

  hold_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (s_release_por and opt_w.hold_short) |-> hold_q[*8]) else $error("hold dropped");
endmodule : ocr_top

// *** tb/ocr_testbench.sv ***
`timescale 1ns/10ps
// register bank bench: bus tasks, a reset task, one task per scenario
module testbench;
  import ocr_pkg::*;
  localparam int HL = 32;  // shortened long hold count
  logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_por = 1'b1, i_boot_mode = 1'b1;
  logic i_wait_mode = 1'b0, i_eprom_wr_req = 1'b0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0;
  logic [1:0] bresp, rresp;
  logic hold, wr_ok, wd_run;
  logic [7:0] opts;
  int miscompares = 0, compares = 0, hold_cnt;
  logic [1:0] rs;
  logic [31:0] rd;

  ocr_top #(.HOLD_LONG(HL)) ocr_top_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_por(i_por), .i_boot_mode(i_boot_mode), .i_wait_mode(i_wait_mode),
    .i_eprom_wr_req(i_eprom_wr_req), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .o_reset_pin_low(hold), .o_eprom_wr_ok(wr_ok), .o_wd_run(wd_run), .o_opts(opts));

  // 40 MHz clock
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // verdict and end of run
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // one compare task for every value kind
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // bounded wait guard, a stuck handshake ends the run
  task automatic guard(inout int n);
    n++;
    if (n > 200) begin
      miscompares++;
      $display("CHECK FAILED timeout expected 0 seen %0d", n);
      tally_and_finish();
    end
  endtask : guard

  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [17:0] a, input logic [7:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge i_clk_sys);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      guard(n);
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // read: request held until taken, data taken with rvalid
  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge i_clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      guard(n);
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // reset of either flavour, counts cycles the reset pin stays low
  task automatic do_reset(input logic por, input logic boot);
    int n = 0;
    @(posedge i_clk_sys);
    i_rstn <= 1'b0;
    i_por <= por;
    i_boot_mode <= boot;
    repeat (6) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    hold_cnt = 0;
    // count from the first edge after release; the pin has been low since reset
    forever begin
      @(posedge i_clk_sys);
      #1;
      if (hold !== 1'b1) break;
      hold_cnt++;
      guard(n);
    end
  endtask : do_reset

  // first power-on, erased options: long hold, flag set, watchdog off
  task automatic t_power_on;
    do_reset(1'b1, 1'b1);
    chk("hold_long", HL, hold_cnt);
    axi_rd(ADDR_MISC, rd, rs);
    chk("misc_por", 32'h80, rd);
    i_eprom_wr_req <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk("eprom_open", 1, wr_ok);
    chk("wd_off", 0, wd_run);
    $display("test power_on done");
  endtask : t_power_on

  // program options in bootloader mode, protect takes effect
  task automatic t_program;
    axi_wr(ADDR_OPTS, 8'h5C, rs);
    chk("opts_wresp", RESP_OKAY, rs);
    axi_rd(ADDR_OPTS, rd, rs);
    chk("opts_read", 32'h5C, rd);
    repeat (2) @(posedge i_clk_sys);
    chk("opts_port", 32'h5C, opts);
    chk("eprom_locked", 0, wr_ok);
    axi_rd(18'h00008, rd, rs);
    chk("unmapped_resp", RESP_DECERR, rs);
    chk("unmapped_data", 0, rd);
    $display("test program done");
  endtask : t_program

  // external reset in user mode: options kept, watchdog on, refused write
  task automatic t_user_mode;
    do_reset(1'b0, 1'b0);
    axi_rd(ADDR_OPTS, rd, rs);
    chk("opts_kept", 32'h5C, rd);
    axi_rd(ADDR_MISC, rd, rs);
    chk("misc_watchdog_active_bit", 1, rd[MISC_WATCHDOG_ACTIVE_BIT]);
    i_wait_mode <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk("wd_in_wait", 1, wd_run);
    i_wait_mode <= 1'b0;
    axi_wr(ADDR_OPTS, 8'h00, rs);
    chk("opts_refused", RESP_SLVERR, rs);
    axi_rd(ADDR_OPTS, rd, rs);
    chk("opts_unchanged", 32'h5C, rd);
    $display("test user_mode done");
  endtask : t_user_mode

  // power-on again: short hold; bootstrap keeps watchdog off
  task automatic t_short_hold;
    do_reset(1'b1, 1'b0);
    chk("hold_short", HOLD_SHORT_CYC, hold_cnt);
    axi_rd(ADDR_MISC, rd, rs);
    chk("misc_por2", 32'h81, rd);
    do_reset(1'b1, 1'b1);
    axi_rd(ADDR_MISC, rd, rs);
    chk("misc_boot", 32'h80, rd);
    chk("wd_boot", 0, wd_run);
    $display("test short_hold done");
  endtask : t_short_hold

  // misc writes clear the flag and start the watchdog; control leaves boot mode
  task automatic t_misc_ctrl;
    axi_wr(ADDR_MISC, 8'h01, rs);
    chk("misc_wresp", RESP_OKAY, rs);
    axi_rd(ADDR_MISC, rd, rs);
    chk("misc_cleared", 32'h01, rd);
    chk("wd_started", 1, wd_run);
    axi_rd(ADDR_CTRL, rd, rs);
    chk("ctrl_boot", 32'h01, rd);
    axi_wr(ADDR_CTRL, 8'h00, rs);
    chk("ctrl_wresp", RESP_OKAY, rs);
    axi_rd(ADDR_CTRL, rd, rs);
    chk("ctrl_left", 32'h00, rd);
    axi_wr(ADDR_OPTS, 8'h00, rs);
    chk("opts_after_exit", RESP_SLVERR, rs);
    axi_rd(ADDR_OPTS, rd, rs);
    chk("opts_still", 32'h5C, rd);
    $display("test misc_ctrl done");
  endtask : t_misc_ctrl

  initial begin
    t_power_on();
    t_program();
    t_user_mode();
    t_short_hold();
    t_misc_ctrl();
    tally_and_finish();
  end
endmodule : testbench
